/* dv/charger_asserts.sv */
// Assertion checker for the charger mode control block
`timescale 1ns/10ps
module charger_asserts (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire bat_above_low,
  input wire boost_en,
  input wire rail_above_2v2,
  input wire external_limit_pin_clamp_100ma,
  input wire iin_over_limit,
  input wire charge_current_cut,
  input wire bat_below_minsys,
  input wire pfm_en,
  input wire int_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************
  // Interrupt width
  // ****************
  // Counts low cycles so a pulse of wrong length is caught at its end
  int unsigned lo_cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      lo_cnt <= 0;
    else if (!int_n)
      lo_cnt <= lo_cnt + 1;
    else
      lo_cnt <= 0;
  end
  property p_ready_next;
    psel && !penable && ce |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no answer in access cycle");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_boost_drop;
    ce && !bat_above_low |=> !boost_en;
  endproperty
  a_boost_drop: assert property (p_boost_drop) else $error("boost on, battery low");
  property p_clamp;
    !rail_above_2v2 |-> ##[1:2] external_limit_pin_clamp_100ma;
  endproperty
  a_clamp: assert property (p_clamp) else $error("limit not clamped");
  property p_cut;
    iin_over_limit |-> ##[1:2] charge_current_cut;
  endproperty
  a_cut: assert property (p_cut) else $error("charge current not cut");
  property p_pfm;
    bat_below_minsys |-> ##[1:2] pfm_en;
  endproperty
  a_pfm: assert property (p_pfm) else $error("light load mode missing");
  property p_int_len;
    $rose(int_n) |-> lo_cnt == 2560;
  endproperty
  a_int_len: assert property (p_int_len) else $error("interrupt pulse length");
  property p_int_max;
    !int_n |-> lo_cnt < 2560;
  endproperty
  a_int_max: assert property (p_int_max) else $error("interrupt pulse too long");
endmodule // charger_asserts

bind charger_mode_control charger_asserts i_charger_asserts (.pclk, .presetn, .ce, .psel,
  .penable, .pready, .pslverr, .bat_above_low, .boost_en, .rail_above_2v2,
  .external_limit_pin_clamp_100ma, .iin_over_limit, .charge_current_cut, .bat_below_minsys, .pfm_en, .int_n);

/* dv/host_model.sv */
// Host side model: APB master reaching the charger registers
`timescale 1ns/10ps
module host_model (
  input  wire        pclk,
  output logic       psel,
  output logic       penable,
  output logic       pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
  end
  // Control writes (force detect, boost config) come through here
  task automatic xfer(input bit wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output bit tmo);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // No wait state count assumed; pready or the 16-cycle bound ends the wait
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    tmo = (n == 16);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
endmodule // host_model

/* dv/tb_top.sv */
// Testbench for the charger mode control block
`timescale 1ns/10ps
`include "charger_defines.vh"
module tb_top;
  localparam int BD = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic otg_pin, charge_enable_n_pin, input_good, rail_above_2v2, bat_above_low,
    vin_below_sleep, sys_below_bat, bat_depleted, bat_below_minsys, iin_over_limit,
    vin_under_limit, chg_below_term, bat_above_pre, bat_above_rechg, boost_fault,
    thermistor_fault, timer_fault, external_limit_pin_lower;
  logic converter_en, high_side_switch, low_side_switch, battery_switch, boost_en,
    boost_external_limit_pin_high, external_limit_pin_clamp_100ma, external_limit_pin_use_pin, charge_current_cut, pfm_en,
    minsys_raise, stat_o, stat_oe, int_n;
  int miscompares = 0;
  int check_count = 0;
  int waited;
  charger_mode_control #(.BOOST_DELAY(BD), .BLINK_HALF(8)) i_charger_mode_control (
    .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .otg_pin, .charge_enable_n_pin, .input_good, .rail_above_2v2,
    .bat_above_low, .vin_below_sleep, .sys_below_bat, .bat_depleted, .bat_below_minsys,
    .iin_over_limit, .vin_under_limit, .chg_below_term, .bat_above_pre, .bat_above_rechg,
    .boost_fault, .thermistor_fault, .timer_fault, .external_limit_pin_lower,
    .converter_en, .high_side_switch, .low_side_switch, .battery_switch, .boost_en,
    .boost_external_limit_pin_high, .external_limit_pin_clamp_100ma, .external_limit_pin_use_pin, .charge_current_cut, .pfm_en,
    .minsys_raise, .stat_o, .stat_oe, .int_n);
  host_model i_host_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rw(input bit wr, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] rd, output logic err);
    bit tmo;
    i_host_model.xfer(wr, a, d, rd, err, tmo);
    if (tmo) begin
      miscompares++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    rw(1, a, {24'h0, d}, rd, err);
  endtask
  // Polls because status follows the inputs a few cycles late
  task automatic rd_exp(input string what, input logic [11:0] a, input logic [7:0] m, e);
    logic [31:0] d;
    logic err;
    for (int n = 0; n < 64; n++) begin
      rw(0, a, 0, d, err);
      if ((d[7:0] & m) === e)
        break;
    end
    chk(what, e, d[7:0] & m);
  endtask
  task automatic wait_lvl(input string what, ref logic s, input logic v, input int lim);
    for (waited = 0; waited < lim && s !== v; waited++)
      @(posedge pclk);
    chk(what, v, s);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_regs;
    logic [11:0] ad[6] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h01c};
    logic [7:0] ex[6] = '{8'h30, 8'h1b, 8'h60, 8'h11, 8'hb2, 8'h4b};
    logic [31:0] d;
    logic err;
    chk("clamp", 1, external_limit_pin_clamp_100ma);
    for (int i = 0; i < 6; i++)
      rd_exp("reset value", ad[i], 8'hff, ex[i]);
    rw(0, 12'h0fc, 0, d, err);
    chk("unmapped error", 1, err);
    rail_above_2v2 <= 1;
    wait_lvl("clamp off", external_limit_pin_clamp_100ma, 0, 8);
    external_limit_pin_lower <= 1;
    wait_lvl("pin limit", external_limit_pin_use_pin, 1, 8);
    $display("regs done");
  endtask
  task automatic t_force;
    wr(`ADDR_MISC_OPERATION_CTRL, 8'hcb);
    rd_exp("force clears", `ADDR_MISC_OPERATION_CTRL, 8'hff, 8'h4b);
    $display("force done");
  endtask
  task automatic t_boost;
    wr(`ADDR_POWER_ON_CONFIG, 8'h2b);
    otg_pin <= 1;
    vin_below_sleep <= 1;
    repeat (8) @(posedge pclk);
    bat_above_low <= 1;
    wait_lvl("boost on", boost_en, 1, 40);
    chk("boost delay", 1, waited >= BD);
    chk("boost high limit", 1, boost_external_limit_pin_high);
    rd_exp("boost source", `ADDR_SYSTEM_STATUS, 8'hc0, 8'hc0);
    wr(`ADDR_POWER_ON_CONFIG, 8'h2a);
    wait_lvl("boost low limit", boost_external_limit_pin_high, 0, 8);
    boost_fault <= 1;
    rd_exp("boost fault flag", `ADDR_FAULT_FLAGS, 8'h40, 8'h40);
    wait_lvl("fault interrupt", int_n, 0, 8);
    boost_fault <= 0;
    bat_above_low <= 0;
    wait_lvl("boost off", boost_en, 0, 4);
    otg_pin <= 0;
    wait_lvl("interrupt end", int_n, 1, 3000);
    $display("boost done");
  endtask
  task automatic t_dpm;
    wr(`ADDR_POWER_ON_CONFIG, 8'h1b);
    input_good <= 1;
    bat_above_pre <= 1;
    charge_enable_n_pin <= 0;
    wait_lvl("converter on", converter_en, 1, 8);
    wait_lvl("switching", high_side_switch, 1, 8);
    chk("low side", 1, low_side_switch);
    iin_over_limit <= 1;
    wait_lvl("cut", charge_current_cut, 1, 8);
    rd_exp("dpm status", `ADDR_SYSTEM_STATUS, 8'h08, 8'h08);
    iin_over_limit <= 0;
    vin_under_limit <= 1;
    rd_exp("dpm status v", `ADDR_SYSTEM_STATUS, 8'h08, 8'h08);
    vin_under_limit <= 0;
    wait_lvl("cut off", charge_current_cut, 0, 8);
    bat_below_minsys <= 1;
    wait_lvl("pfm low battery", pfm_en, 1, 8);
    bat_below_minsys <= 0;
    wait_lvl("pfm off", pfm_en, 0, 8);
    $display("dpm done");
  endtask
  task automatic t_charge;
    rd_exp("phase fast", `ADDR_SYSTEM_STATUS, 8'h30, 8'h20);
    wait_lvl("stat low", stat_oe, 1, 8);
    chk("switch on", 1, battery_switch);
    chg_below_term <= 1;
    bat_above_rechg <= 1;
    rd_exp("phase done", `ADDR_SYSTEM_STATUS, 8'h30, 8'h30);
    wait_lvl("done interrupt", int_n, 0, 8);
    wait_lvl("stat high", stat_oe, 0, 8);
    bat_above_rechg <= 0;
    bat_above_pre <= 0;
    rd_exp("phase pre", `ADDR_SYSTEM_STATUS, 8'h30, 8'h10);
    thermistor_fault <= 1;
    rd_exp("fault stops charge", `ADDR_SYSTEM_STATUS, 8'h30, 8'h00);
    wait_lvl("blink off", stat_oe, 0, 20);
    wait_lvl("blink on", stat_oe, 1, 20);
    wait_lvl("blink off again", stat_oe, 0, 20);
    chk("blink half period", 8, waited);
    thermistor_fault <= 0;
    wr(`ADDR_POWER_ON_CONFIG, 8'h0b);
    rd_exp("phase off", `ADDR_SYSTEM_STATUS, 8'h31, 8'h01);
    wait_lvl("switch off", battery_switch, 0, 8);
    sys_below_bat <= 1;
    wait_lvl("supplement on", battery_switch, 1, 8);
    bat_depleted <= 1;
    wait_lvl("supplement off", battery_switch, 0, 8);
    $display("charge done");
  endtask
  task automatic t_reset;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk("reset interrupt", 1, int_n);
    chk("reset clamp", 1, external_limit_pin_clamp_100ma);
    presetn <= 1;
    rd_exp("config after reset", `ADDR_POWER_ON_CONFIG, 8'hff, 8'h1b);
    $display("reset done");
  endtask
  initial begin
    {presetn, otg_pin, input_good, rail_above_2v2, bat_above_low, vin_below_sleep} = 0;
    {sys_below_bat, bat_depleted, bat_below_minsys, iin_over_limit, vin_under_limit} = 0;
    {chg_below_term, bat_above_pre, bat_above_rechg, boost_fault, thermistor_fault} = 0;
    {timer_fault, external_limit_pin_lower} = 0;
    charge_enable_n_pin = 1;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_force();
    t_boost();
    t_dpm();
    t_charge();
    t_reset();
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
endmodule // tb_top

/* verilog/charger_defines.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef CHARGER_DEFINES_VH
`define CHARGER_DEFINES_VH

`define ADDR_INPUT_SOURCE_CTRL   12'h000
`define ADDR_POWER_ON_CONFIG     12'h004
`define ADDR_CHARGE_CURRENT_CTRL 12'h008
`define ADDR_PRECHARGE_CTRL      12'h00c
`define ADDR_CHARGE_VOLTAGE_CTRL 12'h010
`define ADDR_MISC_OPERATION_CTRL 12'h01c
`define ADDR_SYSTEM_STATUS       12'h020
`define ADDR_FAULT_FLAGS         12'h024
`define ADDR_CONV_STATUS         12'h028

`define RST_INPUT_SOURCE_CTRL    8'h30
`define RST_POWER_ON_CONFIG      8'h1b
`define RST_CHARGE_CURRENT_CTRL  8'h60
`define RST_PRECHARGE_CTRL       8'h11
`define RST_CHARGE_VOLTAGE_CTRL  8'hb2
`define RST_MISC_OPERATION_CTRL  8'h4b

`define FLD_FORCE_DET            7
`define FLD_BATSW_OFF            5
`define FLD_BOOST_EXTERNAL_LIMIT_PIN           0
`define FLD_BOOST_FAULT          6
`define FLD_DPM_STAT             3
`define FLD_MINSYS_STAT          0
`define FLD_CHG_CFG_HI           5
`define FLD_CHG_CFG_LO           4
`define FLD_RECHG                0
`define FLD_BATLOW               1

`define CFG_DISABLE              2'b00
`define CFG_CHARGE               2'b01
`define CFG_BOOST                2'b10
`define SRC_BOOST                2'b11
`define PH_DISABLED              2'b00
`define PH_PRE                   2'b01
`define PH_FAST                  2'b10
`define PH_DONE                  2'b11
`define EXTERNAL_LIMIT_PIN_100MA               3'h0

`define CLK_HZ                   10000000
`define BOOST_DELAY_MS           220
`define BOOST_DELAY_CYC          ((`BOOST_DELAY_MS * (`CLK_HZ / 1000)))
`define INT_PULSE_US             256
`define INT_PULSE_CYC            ((`INT_PULSE_US * (`CLK_HZ / 1000000)))
`define BLINK_HZ                 1
`define BLINK_HALF_CYC           ((`CLK_HZ / (2 * `BLINK_HZ)))
`define DETECT_CYC               16

`endif

/* verilog/charger_mode_control.v */
// Charger mode control: APB registers, boost, power path, charge cycle
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
`include "charger_defines.vh"
module charger_mode_control #(
  parameter BOOST_DELAY = `BOOST_DELAY_CYC,
  parameter BLINK_HALF  = `BLINK_HALF_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        otg_pin,
  input  wire        charge_enable_n_pin,
  input  wire        input_good,
  input  wire        rail_above_2v2,
  input  wire        bat_above_low,
  input  wire        vin_below_sleep,
  input  wire        sys_below_bat,
  input  wire        bat_depleted,
  input  wire        bat_below_minsys,
  input  wire        iin_over_limit,
  input  wire        vin_under_limit,
  input  wire        chg_below_term,
  input  wire        bat_above_pre,
  input  wire        bat_above_rechg,
  input  wire        boost_fault,
  input  wire        thermistor_fault,
  input  wire        timer_fault,
  input  wire        external_limit_pin_lower,
  output reg         converter_en,
  output reg         high_side_switch,
  output reg         low_side_switch,
  output reg         battery_switch,
  output reg         boost_en,
  output reg         boost_external_limit_pin_high,
  output reg         external_limit_pin_clamp_100ma,
  output reg         external_limit_pin_use_pin,
  output reg         charge_current_cut,
  output reg         pfm_en,
  output reg         minsys_raise,
  output reg         stat_o,
  output reg         stat_oe,
  output reg         int_n
);

  // ****************************************************************
  // Decoding shared by read and write paths
  // ****************************************************************
  function is_addr;
    input [11:0] a;
    input [11:0] base;
    begin
      is_addr = (a[11:2] == base[11:2]);
    end
  endfunction
  localparam ST_IDLE = 4'b0001;
  localparam ST_PRE  = 4'b0010;
  localparam ST_FAST = 4'b0100;
  localparam ST_DONE = 4'b1000;
  reg  [7:0]  input_source_ctrl_r;
  reg  [7:0]  power_on_config_r;
  reg  [7:0]  charge_current_ctrl_r;
  reg  [7:0]  precharge_ctrl_r;
  reg  [7:0]  charge_voltage_ctrl_r;
  reg  [7:0]  misc_operation_ctrl_r;
  reg         boost_fault_flag_r;
  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [2:0]  det_cnt_r;
  reg  [31:0] boost_cnt_r;
  reg  [31:0] blink_cnt_r;
  reg         blink_r;
  reg         supplement_r;
  reg         done_evt_r;
  reg         boost_evt_r;
  wire        otg_s;
  wire        chg_en_s;
  wire        int_pulse;
  wire        wr_en;
  wire        rd_en;
  wire [1:0]  chg_cfg;
  wire        batsw_forced_off;
  wire        boost_qual;
  wire        boost_ok;
  wire        chg_allowed;
  wire        chg_fault;
  wire        dpm_active;
  wire [1:0]  phase;
  wire [1:0]  src_stat;
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  pin_sync u_sync_otg (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (otg_pin),
    .dout    (otg_s)
  );
  // Inverted so the synchroniser's reset value reads as disabled
  pin_sync u_sync_ce (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (!charge_enable_n_pin),
    .dout    (chg_en_s)
  );
  assign wr_en = psel && penable && pwrite && ce;
  assign rd_en = psel && !penable && !pwrite && ce;
  assign chg_cfg = power_on_config_r[`FLD_CHG_CFG_HI:`FLD_CHG_CFG_LO];
  assign batsw_forced_off = misc_operation_ctrl_r[`FLD_BATSW_OFF];
  assign chg_fault = thermistor_fault || timer_fault;
  assign dpm_active = iin_over_limit || vin_under_limit;
  // ****************************************************************
  // Host registers
  // ****************************************************************
  // Writes keep their value until rewritten or reset, except the force-detect bit, which clears itself
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_source_ctrl_r   <= `RST_INPUT_SOURCE_CTRL;
      power_on_config_r     <= `RST_POWER_ON_CONFIG;
      charge_current_ctrl_r <= `RST_CHARGE_CURRENT_CTRL;
      precharge_ctrl_r      <= `RST_PRECHARGE_CTRL;
      charge_voltage_ctrl_r <= `RST_CHARGE_VOLTAGE_CTRL;
      misc_operation_ctrl_r <= `RST_MISC_OPERATION_CTRL;
      det_cnt_r             <= 3'h0;
    end else if (ce) begin
      if (wr_en && is_addr(paddr, `ADDR_INPUT_SOURCE_CTRL)) begin
        input_source_ctrl_r <= pwdata[7:0];
      end else if (wr_en && is_addr(paddr, `ADDR_POWER_ON_CONFIG)) begin
        power_on_config_r <= pwdata[7:0];
      end else if (wr_en && is_addr(paddr, `ADDR_CHARGE_CURRENT_CTRL)) begin
        charge_current_ctrl_r <= pwdata[7:0];
      end else if (wr_en && is_addr(paddr, `ADDR_PRECHARGE_CTRL)) begin
        precharge_ctrl_r <= pwdata[7:0];
      end else if (wr_en && is_addr(paddr, `ADDR_CHARGE_VOLTAGE_CTRL)) begin
        charge_voltage_ctrl_r <= pwdata[7:0];
      end
      // Force-detect: host write sets, detection end clears itself
      if (wr_en && is_addr(paddr, `ADDR_MISC_OPERATION_CTRL)) begin
        misc_operation_ctrl_r <= pwdata[7:0];
        det_cnt_r <= pwdata[`FLD_FORCE_DET] ? 3'h7 : 3'h0;
      end else if (misc_operation_ctrl_r[`FLD_FORCE_DET]) begin
        if (det_cnt_r == 3'h0) begin
          misc_operation_ctrl_r[`FLD_FORCE_DET] <= 1'b0;
        end else begin
          det_cnt_r <= det_cnt_r - 3'h1;
        end
      end
    end
  end

  // ****************************************************************
  // Boost qualification and delay
  // ****************************************************************
  assign boost_qual = bat_above_low && vin_below_sleep && otg_s &&
                      (chg_cfg == `CFG_BOOST);
  assign boost_ok = boost_qual && (boost_cnt_r >= BOOST_DELAY - 1);
  // Restarts whenever any condition drops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_cnt_r <= 32'h00000000;
      boost_fault_flag_r <= 1'b0;
      boost_evt_r <= 1'b0;
    end else if (ce) begin
      if (!boost_qual) begin
        boost_cnt_r <= 32'h00000000;
      end else if (!boost_ok) begin
        boost_cnt_r <= boost_cnt_r + 32'h00000001;
      end
      boost_evt_r <= boost_en && boost_fault && !boost_fault_flag_r;
      // Fault set wins over a same-cycle read clear
      if (boost_en && boost_fault) begin
        boost_fault_flag_r <= 1'b1;
      end else if (rd_en && is_addr(paddr, `ADDR_FAULT_FLAGS)) begin
        boost_fault_flag_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Charge cycle
  // ****************************************************************
  assign chg_allowed = converter_en && (chg_cfg == `CFG_CHARGE) && chg_en_s &&
                       !chg_fault && !batsw_forced_off;
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (chg_allowed) begin
          state_nxt = bat_above_pre ? ST_FAST : ST_PRE;
        end
      end
      ST_PRE: begin
        if (!chg_allowed) begin
          state_nxt = ST_IDLE;
        end else if (bat_above_pre) begin
          state_nxt = ST_FAST;
        end
      end
      ST_FAST: begin
        if (!chg_allowed) begin
          state_nxt = ST_IDLE;
        end else if (chg_below_term && bat_above_rechg && !dpm_active) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!chg_allowed) begin
          state_nxt = ST_IDLE;
        end else if (!bat_above_rechg) begin
          state_nxt = bat_above_pre ? ST_FAST : ST_PRE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      done_evt_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      done_evt_r <= (state_nxt == ST_DONE) && (state_r != ST_DONE);
    end
  end

  assign phase = (state_r == ST_PRE)  ? `PH_PRE :
                 (state_r == ST_FAST) ? `PH_FAST :
                 (state_r == ST_DONE) ? `PH_DONE : `PH_DISABLED;
  assign src_stat = boost_en ? `SRC_BOOST : 2'b00;
  // ****************************************************************
  // Interrupt pulse
  // ****************************************************************
  event_pulse #(
    .LEN (`INT_PULSE_CYC)
  ) u_int (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .evt     (done_evt_r || boost_evt_r),
    .pulse   (int_pulse)
  );

  // ****************************************************************
  // Power path and converter outputs
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_en       <= 1'b0;
      high_side_switch   <= 1'b0;
      low_side_switch    <= 1'b0;
      battery_switch     <= 1'b0;
      boost_en           <= 1'b0;
      boost_external_limit_pin_high    <= 1'b0;
      external_limit_pin_clamp_100ma   <= 1'b1;
      external_limit_pin_use_pin       <= 1'b0;
      charge_current_cut <= 1'b0;
      pfm_en             <= 1'b0;
      minsys_raise       <= 1'b0;
      supplement_r       <= 1'b0;
      int_n              <= 1'b1;
    end else if (ce) begin
      // Converter waits for limit detection to finish
      converter_en     <= input_good && !misc_operation_ctrl_r[`FLD_FORCE_DET]
                          && !boost_ok;
      high_side_switch <= converter_en || boost_en;
      low_side_switch  <= converter_en || boost_en;
      boost_en         <= boost_ok;
      boost_external_limit_pin_high  <= power_on_config_r[`FLD_BOOST_EXTERNAL_LIMIT_PIN];
      external_limit_pin_clamp_100ma <= !rail_above_2v2;
      external_limit_pin_use_pin     <= rail_above_2v2 && external_limit_pin_lower;
      charge_current_cut <= dpm_active;
      if (sys_below_bat && !bat_depleted) begin
        supplement_r <= 1'b1;
      end else if (bat_depleted) begin
        supplement_r <= 1'b0;
      end
      battery_switch   <= !batsw_forced_off &&
                          ((state_r != ST_IDLE && state_r != ST_DONE) ||
                           supplement_r || boost_en);
      pfm_en           <= bat_below_minsys || (chg_cfg != `CFG_CHARGE);
      minsys_raise     <= (state_r == ST_IDLE) || (state_r == ST_DONE);
      int_n            <= !int_pulse;
    end
  end

  // ****************************************************************
  // Status pin with fault blink
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_r <= 32'h00000000;
      blink_r     <= 1'b0;
      stat_o      <= 1'b0;
      stat_oe     <= 1'b0;
    end else if (ce) begin
      if (blink_cnt_r >= BLINK_HALF - 1) begin
        blink_cnt_r <= 32'h00000000;
        blink_r     <= !blink_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 32'h00000001;
      end
      stat_o <= 1'b0;
      // Open drain: enable pulls low, released means high
      if (chg_fault && chg_cfg == `CFG_CHARGE) begin
        stat_oe <= blink_r;
      end else begin
        stat_oe <= (state_r == ST_PRE) || (state_r == ST_FAST);
      end
    end
  end

  // ****************************************************************
  // APB slave: zero wait state, error on unmapped address
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        if (is_addr(paddr, `ADDR_INPUT_SOURCE_CTRL)) begin
          prdata[7:0] <= input_source_ctrl_r;
        end else if (is_addr(paddr, `ADDR_POWER_ON_CONFIG)) begin
          prdata[7:0] <= power_on_config_r;
        end else if (is_addr(paddr, `ADDR_CHARGE_CURRENT_CTRL)) begin
          prdata[7:0] <= charge_current_ctrl_r;
        end else if (is_addr(paddr, `ADDR_PRECHARGE_CTRL)) begin
          prdata[7:0] <= precharge_ctrl_r;
        end else if (is_addr(paddr, `ADDR_CHARGE_VOLTAGE_CTRL)) begin
          prdata[7:0] <= charge_voltage_ctrl_r;
        end else if (is_addr(paddr, `ADDR_MISC_OPERATION_CTRL)) begin
          prdata[7:0] <= misc_operation_ctrl_r;
        end else if (is_addr(paddr, `ADDR_SYSTEM_STATUS)) begin
          prdata[7:0] <= {src_stat, phase, dpm_active, input_good, 1'b0,
                          minsys_raise};
        end else if (is_addr(paddr, `ADDR_FAULT_FLAGS)) begin
          prdata[7:0] <= {1'b0, boost_fault_flag_r, timer_fault, 1'b0, 1'b0,
                          thermistor_fault, 2'b00};
        end else if (is_addr(paddr, `ADDR_CONV_STATUS)) begin
          prdata[7:0] <= {2'b00, pfm_en, supplement_r, battery_switch,
                          charge_current_cut, boost_en, converter_en};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule // charger_mode_control

/* verilog/event_pulse.v */
// Stretches one-cycle events into a fixed-length interrupt pulse
`timescale 1ns/10ps
module event_pulse #(
  parameter LEN = 2560
) (
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  input  wire evt,
  output reg  pulse
);
  reg [11:0] cnt_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 12'h000;
      pulse <= 1'b0;
    end else if (ce) begin
      if (evt && !pulse) begin
        cnt_r <= LEN[11:0] - 12'h001;
        pulse <= 1'b1;
      end else if (cnt_r != 12'h000) begin
        cnt_r <= cnt_r - 12'h001;
      end else begin
        pulse <= 1'b0;
      end
    end
  end
endmodule // event_pulse

/* verilog/pin_sync.v */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  input  wire din,
  output reg  dout
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Change accepted once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule // pin_sync
